// ### inc/serdes_pkg.sv
`default_nettype none
package serdes_pkg;

  // word and frame layout: start bit, ten data bits LSB first, stop bit
  localparam int WORD_W = 10;
  localparam logic [3:0] STOP_IDX = 4'hb;
  localparam logic [3:0] MID_IDX = 4'h6;
  localparam logic [9:0] TRAIN_WORD = 10'h3e0; // five ones, five zeros

  // reset values
  localparam logic LOCK_N_RST = 1'h1;
  localparam logic [9:0] WORD_RST = 10'h000;

  // reference clock watchdog: longest quiet time before it counts as absent
  localparam int CLK_PERIOD_PS = 4000;
  localparam int REF_TIMEOUT_NS = 400;
  localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_FRAME = 2'b10
  } rx_state_type;

  // every pin that enters from outside the clock domain
  typedef struct packed {
    logic [9:0] tx_word;
    logic word_clk;
    logic tsel;
    logic [1:0] train;
    logic ser_en;
    logic tx_awake;
    logic rx_pos;
    logic rx_neg;
    logic ref_clk;
    logic rsel;
    logic ren;
    logic rx_awake;
  } pin_in_type;

  // receiver parallel outputs
  typedef struct packed {
    logic [9:0] word;
    logic lock_n;
    logic rclk;
  } rx_out_type;

endpackage : serdes_pkg
`default_nettype wire

// ### rtl/embedded_clock_serdes_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module embedded_clock_serdes_ctrl
  import serdes_pkg::*;
#(
  parameter int BIT_CYCLES = 4,
  parameter int LOCK_FRAMES = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [9:0] tx_word_i,
  input wire logic transmit_word_clock_i,
  input wire logic transmit_edge_select_i,
  input wire logic [1:0] training_request_i,
  input wire logic serial_output_enable_i,
  input wire logic tx_sleep_request_n_i,
  output logic serial_out_pos_o,
  output logic serial_out_neg_o,
  output logic serial_out_oe_n_o,
  input wire logic serial_in_pos_i,
  input wire logic serial_in_neg_i,
  input wire logic receiver_reference_clock_i,
  input wire logic rx_edge_select_i,
  input wire logic rx_output_enable_i,
  input wire logic rx_sleep_request_n_i,
  output var rx_out_type parallel_out_o,
  output logic rx_oe_n_o
);

  if (BIT_CYCLES < 2 || BIT_CYCLES > 16) begin : g_bad_bit
    $error("BIT_CYCLES must lie in 2..16");
  end
  if (LOCK_FRAMES < 1 || LOCK_FRAMES > 255) begin : g_bad_lock
    $error("LOCK_FRAMES must lie in 1..255");
  end

  localparam logic [3:0] LAST_PH = 4'(BIT_CYCLES - 1);
  localparam logic [3:0] HALF_PH = 4'(BIT_CYCLES / 2);
  localparam logic [7:0] LOCK_N = 8'(LOCK_FRAMES);
  localparam logic [7:0] REF_TO = 8'(REF_TIMEOUT_CYC);

  pin_in_type pin_raw, meta_r, s_r;
  logic word_clk_prev_r, tx_cap, train, tx_tick;
  logic [9:0] tx_word_r;
  logic [11:0] tx_frame_r;
  logic [3:0] tx_div_r, tx_idx_r;
  logic ser_bit_r;

  // gather pins, then two flip-flops before any logic looks at them
  assign pin_raw = '{tx_word: tx_word_i, word_clk: transmit_word_clock_i,
    tsel: transmit_edge_select_i, train: training_request_i,
    ser_en: serial_output_enable_i, tx_awake: tx_sleep_request_n_i,
    rx_pos: serial_in_pos_i, rx_neg: serial_in_neg_i,
    ref_clk: receiver_reference_clock_i, rsel: rx_edge_select_i,
    ren: rx_output_enable_i, rx_awake: rx_sleep_request_n_i};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      s_r <= '0;
    end else begin
      meta_r <= pin_raw;
      s_r <= meta_r;
    end
  end

  // ---------------- serializer ----------------
  // capture edge follows the edge select pin
  assign tx_cap = s_r.tsel ? (s_r.word_clk & ~word_clk_prev_r)
                           : (~s_r.word_clk & word_clk_prev_r);
  assign train = |s_r.train;
  assign tx_tick = (tx_div_r == LAST_PH);

  // input word register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      word_clk_prev_r <= 1'h0;
      tx_word_r <= WORD_RST;
    end else begin
      word_clk_prev_r <= s_r.word_clk;
      if (s_r.tx_awake && tx_cap) begin
        tx_word_r <= s_r.tx_word;
      end
    end
  end

  // bit divider and frame shifter; sleep holds everything idle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_div_r <= 4'h0;
      tx_idx_r <= STOP_IDX;
      tx_frame_r <= 12'h000;
      ser_bit_r <= 1'h0;
    end else if (!s_r.tx_awake) begin
      tx_div_r <= 4'h0;
      tx_idx_r <= STOP_IDX;
      tx_frame_r <= 12'h000;
      ser_bit_r <= 1'h0;
    end else begin
      tx_div_r <= tx_tick ? 4'h0 : tx_div_r + 4'h1;
      if (tx_tick && tx_idx_r == STOP_IDX) begin
        tx_idx_r <= 4'h0;
        tx_frame_r <= {1'h0, train ? TRAIN_WORD : tx_word_r, 1'h1};
      end else if (tx_tick) begin
        tx_idx_r <= tx_idx_r + 4'h1;
      end
      ser_bit_r <= tx_frame_r[tx_idx_r];
    end
  end

  assign serial_out_pos_o = ser_bit_r;
  assign serial_out_neg_o = ~ser_bit_r;
  assign serial_out_oe_n_o = ~(s_r.ser_en & s_r.tx_awake);

  // ---------------- deserializer ----------------
  rx_state_type rx_state_r;
  logic rx_bit, rx_prev_r, rx_sample, frame_done, frame_good, ref_ok;
  logic [3:0] rx_ph_r, rx_idx_r;
  logic [11:0] rx_shift_r;
  logic [7:0] good_cnt_r, ref_cnt_r;
  logic ref_prev_r, lock_n_r, rclk_r;
  logic [9:0] word_r;

  assign rx_bit = s_r.rx_pos & ~s_r.rx_neg;
  assign rx_sample = (rx_state_r == RX_FRAME) && (rx_ph_r == HALF_PH);
  assign frame_done = rx_sample && (rx_idx_r == STOP_IDX);
  assign frame_good = rx_shift_r[0] & ~rx_bit;
  assign ref_ok = (ref_cnt_r < REF_TO);

  // reference clock watchdog: quiet cycles since its last edge
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_prev_r <= 1'h0;
      ref_cnt_r <= REF_TO;
    end else begin
      ref_prev_r <= s_r.ref_clk;
      if (s_r.ref_clk != ref_prev_r) begin
        ref_cnt_r <= 8'h00;
      end else if (ref_cnt_r < REF_TO) begin
        ref_cnt_r <= ref_cnt_r + 8'h01;
      end
    end
  end

  // frame recovery: align on the stop-to-start edge, sample mid-bit
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_state_r <= RX_HUNT;
      rx_prev_r <= 1'h0;
      rx_ph_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_shift_r <= 12'h000;
    end else begin
      rx_prev_r <= rx_bit;
      case (rx_state_r)
        RX_HUNT: begin
          // the detect cycle is phase 0 of the start bit
          rx_ph_r <= 4'h1;
          rx_idx_r <= 4'h0;
          if (s_r.rx_awake && ref_ok && rx_bit && !rx_prev_r) begin
            rx_state_r <= RX_FRAME;
          end
        end
        RX_FRAME: begin
          rx_ph_r <= (rx_ph_r == LAST_PH) ? 4'h0 : rx_ph_r + 4'h1;
          if (rx_ph_r == LAST_PH) begin
            rx_idx_r <= rx_idx_r + 4'h1;
          end
          if (rx_sample) begin
            rx_shift_r[rx_idx_r] <= rx_bit;
          end
          if (frame_done || !s_r.rx_awake) begin
            rx_state_r <= RX_HUNT;
          end
        end
        default: rx_state_r <= RX_HUNT;
      endcase
    end
  end

  // lock: a run of good frames with a live reference; any fault drops it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      good_cnt_r <= 8'h00;
      lock_n_r <= LOCK_N_RST;
    end else if (!s_r.rx_awake || !ref_ok) begin
      good_cnt_r <= 8'h00;
      lock_n_r <= 1'h1;
    end else if (frame_done && !frame_good) begin
      good_cnt_r <= 8'h00;
      lock_n_r <= 1'h1;
    end else if (frame_done) begin
      if (good_cnt_r < LOCK_N) begin
        good_cnt_r <= good_cnt_r + 8'h01;
      end
      if (good_cnt_r + 8'h01 >= LOCK_N) begin
        lock_n_r <= 1'h0;
      end
    end
  end

  // word and recovered clock: active edge falls mid-word, word changes
  // on the opposite edge so the strobe sees a settled value
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      word_r <= WORD_RST;
      rclk_r <= 1'h0;
    end else if (frame_done && frame_good) begin
      word_r <= rx_shift_r[10:1];
      rclk_r <= ~s_r.rsel;
    end else if (rx_sample && rx_idx_r == MID_IDX) begin
      rclk_r <= s_r.rsel;
    end
  end

  assign parallel_out_o = '{word: word_r, lock_n: lock_n_r, rclk: rclk_r};
  assign rx_oe_n_o = ~(s_r.ren & s_r.rx_awake);

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_rx_out_float: assert property (!s_r.ren |-> rx_oe_n_o)
    else $error("receiver outputs driven while disabled");
  a_rx_sleep_float: assert property (
    !s_r.rx_awake |-> rx_oe_n_o ##1 lock_n_r)
    else $error("sleeping receiver not floated or still locked");
  a_lock_gain: assert property (
    frame_done && frame_good && s_r.rx_awake && ref_ok &&
    good_cnt_r >= LOCK_N - 8'h01 |=> !lock_n_r)
    else $error("lock not shown after enough good frames");
  a_lock_drop: assert property (
    frame_done && !frame_good |=> lock_n_r && good_cnt_r == 8'h00)
    else $error("bad frame left lock asserted");
  a_rclk_phase: assert property (
    frame_done && frame_good |=> rclk_r == $past(!s_r.rsel) &&
    word_r == $past(rx_shift_r[10:1]))
    else $error("word and recovered clock out of step");
  a_word_hold: assert property (
    rx_state_r == RX_HUNT && !frame_done |=> $stable(word_r))
    else $error("word changed with no frame");
  a_tx_capture: assert property (
    tx_cap && s_r.tx_awake |=> tx_word_r == $past(s_r.tx_word))
    else $error("input word not captured on selected edge");
  a_tx_train: assert property (
    tx_tick && tx_idx_r == STOP_IDX && s_r.tx_awake && train |=>
    tx_frame_r[10:1] == TRAIN_WORD)
    else $error("training requested but data sent");
  a_tx_float: assert property (
    !s_r.ser_en || !s_r.tx_awake |-> serial_out_oe_n_o)
    else $error("serial output driven while disabled");
  a_tx_sleep: assert property (
    !s_r.tx_awake |=> tx_idx_r == STOP_IDX && tx_div_r == 4'h0)
    else $error("serializer ran while asleep");

  c_lock_gained: cover property (lock_n_r ##1 !lock_n_r);
  c_train_frame: cover property (tx_tick && tx_idx_r == STOP_IDX && train);
  c_good_word: cover property (frame_done && frame_good && !lock_n_r);
  c_lock_lost: cover property (!lock_n_r ##1 lock_n_r);

endmodule : embedded_clock_serdes_ctrl
`default_nettype wire

// ### test/lane_peer.sv
`timescale 1ns/1ps
`default_nettype none
module lane_peer
  import serdes_pkg::*;
#(
  parameter int BIT_CYCLES = 2
) (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic bad_stop_i,
  input wire logic [9:0] word_i,
  output logic pos_o,
  output logic neg_o
);
  logic [11:0] frame_r = 12'h000;
  int phase = 0;
  int idx = 0;
  initial pos_o = 1'h0;
  // frames back to back: start 1, data lsb first, stop 0
  always @(negedge clk_i) begin
    if (!run_i) begin
      phase = 0;
      idx = 0;
      pos_o <= 1'h0; // idle lane rests low
    end else begin
      if (phase == 0 && idx == 0) begin
        frame_r = {bad_stop_i, word_i, 1'h1}; // faulted stop reads 1
      end
      pos_o <= frame_r[idx];
      phase = phase + 1;
      if (phase == BIT_CYCLES) begin
        phase = 0;
        idx = (idx == 11) ? 0 : idx + 1;
      end
    end
  end
  assign neg_o = ~pos_o; // differential pair
endmodule : lane_peer
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import serdes_pkg::*;
;
  localparam int BITC = 2;
  localparam int FRAME = 12 * BITC;
  logic clk_i = 1'h0, reset_i = 1'h1, word_clk = 1'h0, tsel = 1'h1;
  logic ser_en = 1'h1;
  logic tx_sleep_n = 1'h1, rsel = 1'h1, ren = 1'h1, rx_sleep_n = 1'h1;
  logic ref_clk = 1'h0, ref_on = 1'h1, peer_run = 1'h0, peer_bad = 1'h0;
  logic [1:0] train = 2'h0;
  logic [9:0] tx_word = 10'h000, peer_word = TRAIN_WORD;
  logic ser_pos, ser_neg, ser_oe_n, lane_pos, lane_neg, rx_oe_n;
  rx_out_type rx_out;
  int fail_count = 0, check_count = 0, cycles = 0, i, n;
  logic prev;
  embedded_clock_serdes_ctrl #(.BIT_CYCLES(BITC), .LOCK_FRAMES(2))
    embedded_clock_serdes_ctrl_i (
    .clk_i(clk_i), .reset_i(reset_i), .tx_word_i(tx_word),
    .transmit_word_clock_i(word_clk), .transmit_edge_select_i(tsel),
    .training_request_i(train), .serial_output_enable_i(ser_en),
    .tx_sleep_request_n_i(tx_sleep_n), .serial_out_pos_o(ser_pos),
    .serial_out_neg_o(ser_neg), .serial_out_oe_n_o(ser_oe_n),
    .serial_in_pos_i(lane_pos), .serial_in_neg_i(lane_neg),
    .receiver_reference_clock_i(ref_clk), .rx_edge_select_i(rsel),
    .rx_output_enable_i(ren), .rx_sleep_request_n_i(rx_sleep_n),
    .parallel_out_o(rx_out), .rx_oe_n_o(rx_oe_n));
  lane_peer #(.BIT_CYCLES(BITC)) lane_peer_i (.clk_i(clk_i),
    .run_i(peer_run), .bad_stop_i(peer_bad), .word_i(peer_word),
    .pos_o(lane_pos), .neg_o(lane_neg));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // receiver reference clock at a sixth of the system rate
  always begin
    repeat (3) @(negedge clk_i);
    if (ref_on) ref_clk <= ~ref_clk;
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count = fail_count + 1;
      complete_run();
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask : cyc
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    check_count = check_count + 1;
    if (seen !== want) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // realign the peer and wait for the receiver to lock again
  task automatic relock();
    int j;
    peer_run = 1'h0;
    cyc(FRAME);
    peer_run = 1'h1;
    for (j = 0; j < 8 * FRAME && rx_out.lock_n !== 1'h0; j++) cyc(1);
    check(rx_out.lock_n, 1'h0);
  endtask : relock
  // peer sends a word; it must land and be strobed on the chosen edge
  task automatic rx_word(input logic [9:0] w);
    int j;
    peer_word = w;
    for (j = 0; j < 4 * FRAME && rx_out.word !== w; j++) cyc(1);
    check(rx_out.rclk, !rsel);
    for (j = 0; j < FRAME && rx_out.rclk !== rsel; j++) cyc(1);
    check(rx_out.rclk, rsel);
    check(rx_out.word, w);
    check(rx_out.lock_n, 1'h0);
  endtask : rx_word
  // present a word, then make one word clock edge
  task automatic tx_edge(input logic [9:0] w, input logic level);
    tx_word = w;
    cyc(4);
    word_clk = level;
    cyc(4);
  endtask : tx_edge
  // a sleep pulse parks the line low, so the next rise is a start bit
  task automatic tx_frame(input logic [9:0] want);
    logic [9:0] got;
    int j;
    tx_sleep_n = 1'h0;
    cyc(4);
    check(ser_oe_n, 1'h1);
    tx_sleep_n = 1'h1;
    for (j = 0; j < 100 && ser_pos !== 1'h1; j++) cyc(1);
    for (j = 0; j < 10; j++) begin
      cyc(BITC);
      got[j] = ser_pos;
    end
    check(ser_neg, !ser_pos);
    cyc(BITC);
    check(ser_pos, 1'h0);
    check(got, want);
  endtask : tx_frame
  // main sequence
  initial begin
    cyc(1);
    check(rx_out, {WORD_RST, LOCK_N_RST, 1'h0});
    cyc(1);
    reset_i = 1'h0;
    cyc(4);
    check(rx_oe_n, 1'h0);
    peer_run = 1'h1;
    for (i = 0; i < 4 * FRAME && rx_out.word !== TRAIN_WORD; i++) cyc(1);
    check(rx_out.word, TRAIN_WORD);
    check(rx_out.lock_n, 1'h1);
    relock();
    for (n = 0; n < 2; n++) begin
      rsel = (n == 0);
      rx_word(10'h2c5);
      rx_word(10'h13a);
    end
    for (i = 0; i < FRAME && rx_out.rclk !== 1'h0; i++) cyc(1);
    for (i = 0; i < FRAME && rx_out.rclk !== 1'h1; i++) cyc(1);
    n = 0;
    for (i = 0; i < 5 * FRAME - 2; i++) begin
      prev = rx_out.rclk;
      cyc(1);
      if (prev === 1'h0 && rx_out.rclk === 1'h1) n++;
    end
    check(12'(n), 12'h004);
    ren = 1'h0; // outputs float even while locked
    cyc(4);
    check(rx_oe_n, 1'h1);
    ren = 1'h1;
    cyc(4);
    check(rx_oe_n, 1'h0);
    peer_bad = 1'h1;
    for (i = 0; i < 3 * FRAME && rx_out.lock_n !== 1'h1; i++) cyc(1);
    check(rx_out.lock_n, 1'h1);
    peer_bad = 1'h0;
    relock();
    ref_on = 1'h0;
    cyc(60);
    check(rx_out.lock_n, 1'h0);
    cyc(60);
    check(rx_out.lock_n, 1'h1);
    ref_on = 1'h1;
    relock();
    rx_sleep_n = 1'h0;
    cyc(4);
    check({rx_oe_n, rx_out.lock_n}, 12'h003);
    rx_sleep_n = 1'h1;
    relock();
    tx_edge(10'h2c5, 1'h1);
    tx_edge(10'h11b, 1'h0);
    tx_frame(10'h2c5);
    tsel = 1'h0;
    tx_edge(10'h11b, 1'h1);
    tx_frame(10'h2c5);
    tx_edge(10'h11b, 1'h0);
    tx_frame(10'h11b);
    ser_en = 1'h0;
    cyc(4);
    check(ser_oe_n, 1'h1);
    ser_en = 1'h1;
    cyc(4);
    check(ser_oe_n, 1'h0);
    train = 2'h1;
    tx_frame(TRAIN_WORD);
    train = 2'h3;
    cyc(512 * FRAME);
    train = 2'h2; // request held past 1024 frames
    tx_frame(TRAIN_WORD);
    cyc(512 * FRAME);
    train = 2'h0;
    tx_frame(10'h11b);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
